// >>> src/flm_pkg.sv
package flm_pkg;

   // ===========================================
   // Clock and line timing
   localparam longint unsigned CLK_HZ = 250_000_000;
   localparam longint unsigned BIT_RATE_BPS = 1200;
   localparam longint unsigned MARK_HZ = 1200;
   localparam longint unsigned SPACE_HZ = 2200;
   localparam int unsigned BIT_CYCLES = int'(CLK_HZ / BIT_RATE_BPS);
   localparam int unsigned MARK_HALF_CYCLES = int'(CLK_HZ / (2 * MARK_HZ));
   localparam int unsigned SPACE_HALF_CYCLES = int'(CLK_HZ / (2 * SPACE_HZ));
   localparam int unsigned DECIDE_CYCLES = (MARK_HALF_CYCLES + SPACE_HALF_CYCLES) / 2;
   localparam int unsigned CNT_W = 20;

   // ===========================================
   // Tone generator
   localparam int unsigned PHASE_W = 32;
   localparam int unsigned DAC_W = 10;
   localparam logic [PHASE_W-1:0] MARK_INC = PHASE_W'((MARK_HZ << PHASE_W) / CLK_HZ);
   localparam logic [PHASE_W-1:0] SPACE_INC = PHASE_W'((SPACE_HZ << PHASE_W) / CLK_HZ);
   localparam logic [DAC_W-1:0] DAC_MID = 10'h200;

   // ===========================================
   // Receive converter and carrier detect
   localparam int unsigned ADC_W = 12;
   localparam longint unsigned ADC_FS_MV = 1230;
   localparam longint unsigned CD_HI_MV = 120;
   localparam longint unsigned CD_LO_MV = 80;
   localparam logic [ADC_W-1:0] ADC_MID = 12'h800;
   localparam logic [ADC_W-1:0] CD_HI_RST = ADC_W'((CD_HI_MV << ADC_W) / ADC_FS_MV);
   localparam logic [ADC_W-1:0] CD_LO_RST = ADC_W'((CD_LO_MV << ADC_W) / ADC_FS_MV);

   // ===========================================
   // Internal reset pulse
   localparam int unsigned RESET_PULSE_US = 10;
   localparam int unsigned RESET_PULSE_CYCLES = int'(RESET_PULSE_US * (CLK_HZ / 1_000_000));
   localparam int unsigned RST_CNT_W = 12;

   // ===========================================
   // Register map (byte addresses)
   localparam int unsigned ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_CD_HI = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_CD_LO = 8'h14;
   localparam int unsigned CTRL_SW_RESET_BIT = 0;
   localparam int unsigned IRQ_W = 3;
   localparam int unsigned IRQ_CD_RISE_BIT = 0;
   localparam int unsigned IRQ_CD_FALL_BIT = 1;
   localparam int unsigned IRQ_MODE_BIT = 2;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// >>> src/flm_tone_nco.sv
module flm_tone_nco #(
   parameter int unsigned PHASE_W = 32,
   parameter logic [PHASE_W-1:0] MARK_INC = 32'h1,
   parameter logic [PHASE_W-1:0] SPACE_INC = 32'h2
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic selMark,
   output logic [flm_pkg::DAC_W-1:0] dacWord
);

   logic [PHASE_W-1:0] phase;
   logic [PHASE_W-1:0] phaseStep;
   logic [1:0] quadrant;
   logic [3:0] index;
   logic [3:0] tableIndex;
   logic [8:0] amplitude;
   logic [flm_pkg::DAC_W-1:0] next_dacWord;

   // ===========================================
   // Quarter-wave sine table
   function automatic logic [8:0] quarterSine(input logic [3:0] i);
      case (i)
         4'h0: quarterSine = 9'd25;
         4'h1: quarterSine = 9'd75;
         4'h2: quarterSine = 9'd124;
         4'h3: quarterSine = 9'd172;
         4'h4: quarterSine = 9'd218;
         4'h5: quarterSine = 9'd263;
         4'h6: quarterSine = 9'd304;
         4'h7: quarterSine = 9'd343;
         4'h8: quarterSine = 9'd379;
         4'h9: quarterSine = 9'd410;
         4'ha: quarterSine = 9'd438;
         4'hb: quarterSine = 9'd462;
         4'hc: quarterSine = 9'd481;
         4'hd: quarterSine = 9'd496;
         4'he: quarterSine = 9'd505;
         default: quarterSine = 9'd510;
      endcase
   endfunction

   assign phaseStep = selMark ? MARK_INC : SPACE_INC;
   assign quadrant = phase[PHASE_W-1 -: 2];
   assign index = phase[PHASE_W-3 -: 4];
   assign tableIndex = quadrant[0] ? ~index : index;
   assign amplitude = quarterSine(tableIndex);
   assign next_dacWord = quadrant[1] ? (flm_pkg::DAC_MID - {1'b0, amplitude})
                                     : (flm_pkg::DAC_MID + {1'b0, amplitude});

   // ===========================================
   // Phase accumulator
   // Phase kept across switches
   always_ff @(posedge core_clk) begin
      if (!rstn || !enable) begin
         phase <= '0;
         dacWord <= flm_pkg::DAC_MID;
      end else begin
         phase <= phase + phaseStep;
         dacWord <= next_dacWord;
      end
   end

endmodule

// >>> src/flm_modem_core.sv
module flm_modem_core #(
   parameter int unsigned BIT_CYCLES = flm_pkg::BIT_CYCLES,
   parameter int unsigned DECIDE_CYCLES = flm_pkg::DECIDE_CYCLES
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic [flm_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [flm_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic modulateN,
   input wire logic txData,
   output logic rxData,
   output logic carrierDetectOut,
   input wire logic externalClockSelect,
   output logic oscAmpEnable,
   input wire logic [flm_pkg::ADC_W-1:0] toneInput,
   input wire logic toneInputValid,
   output logic [flm_pkg::DAC_W-1:0] toneOutput,
   output logic toneOutputEnable,
   input wire logic resetPinIn,
   output logic resetPinOut,
   output logic resetPinOe,
   output logic irq
);

   localparam int unsigned SYNC_W = 4;
   localparam int unsigned ADC_W = flm_pkg::ADC_W;
   localparam int unsigned CNT_W = flm_pkg::CNT_W;
   localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
   localparam logic [CNT_W-1:0] HALF_SAT = CNT_W'(BIT_CYCLES);
   localparam logic [CNT_W-1:0] DECIDE = CNT_W'(DECIDE_CYCLES);

   // ===========================================
   // Pin synchronisers
   logic [SYNC_W-1:0] syncFirst;
   logic [SYNC_W-1:0] syncSecond;
   logic modulateNSync;
   logic txDataSync;
   logic clockSelectSync;
   logic resetPinSync;

   always_ff @(posedge core_clk) begin
      // Idle levels for request and data, so no false mode edge follows reset
      if (!rstn) begin
         syncFirst <= 4'h3;
         syncSecond <= 4'h3;
      end else begin
         syncFirst <= {resetPinIn, externalClockSelect, txData, modulateN};
         syncSecond <= syncFirst;
      end
   end

   assign modulateNSync = syncSecond[0];
   assign txDataSync = syncSecond[1];
   assign clockSelectSync = syncSecond[2];
   assign resetPinSync = syncSecond[3];

   // ===========================================
   // Registers and mode
   logic [flm_pkg::RST_CNT_W-1:0] rstCount;
   logic [flm_pkg::IRQ_W-1:0] irqStatus;
   logic [flm_pkg::IRQ_W-1:0] irqMask;
   logic [ADC_W-1:0] cdHigh;
   logic [ADC_W-1:0] cdLow;
   logic modemLive;
   logic rxRun;
   logic txRun;

   assign modemLive = resetPinSync && (rstCount == '0);
   assign rxRun = modemLive && modulateNSync;
   assign txRun = modemLive && !modulateNSync;

   // ===========================================
   // AXI4-Lite write channel
   logic [flm_pkg::ADDR_W-1:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   logic wrFire;
   logic wrMapped;
   logic wrCtrl;
   logic wrIrqStatus;
   logic wrIrqMask;
   logic wrCdHigh;
   logic wrCdLow;
   logic [ADC_W-1:0] next_cdHigh;
   logic [ADC_W-1:0] next_cdLow;

   // Both channels held before the write lands, so order does not matter
   assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   assign wrCtrl = awAddr == flm_pkg::ADDR_CTRL;
   assign wrIrqStatus = awAddr == flm_pkg::ADDR_IRQ_STATUS;
   assign wrIrqMask = awAddr == flm_pkg::ADDR_IRQ_MASK;
   assign wrCdHigh = awAddr == flm_pkg::ADDR_CD_HI;
   assign wrCdLow = awAddr == flm_pkg::ADDR_CD_LO;
   assign wrMapped = wrCtrl || wrIrqStatus || wrIrqMask || wrCdHigh || wrCdLow
                     || awAddr == flm_pkg::ADDR_STATUS;
   assign next_cdHigh = {wStrb[1] ? wData[11:8] : cdHigh[11:8],
                         wStrb[0] ? wData[7:0] : cdHigh[7:0]};
   assign next_cdLow = {wStrb[1] ? wData[11:8] : cdLow[11:8],
                        wStrb[0] ? wData[7:0] : cdLow[7:0]};

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= flm_pkg::RESP_OKAY;
         awAddr <= '0;
         wData <= '0;
         wStrb <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awAddr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wrMapped ? flm_pkg::RESP_OKAY : flm_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         irqMask <= flm_pkg::IRQ_MASK_RST;
         cdHigh <= flm_pkg::CD_HI_RST;
         cdLow <= flm_pkg::CD_LO_RST;
      end else if (wrFire) begin
         if (wrIrqMask && wStrb[0]) begin
            irqMask <= wData[flm_pkg::IRQ_W-1:0];
         end
         if (wrCdHigh) begin
            cdHigh <= next_cdHigh;
         end
         if (wrCdLow) begin
            cdLow <= next_cdLow;
         end
      end
   end

   // ===========================================
   // Internal reset drives the pin
   logic swReset;

   assign swReset = wrFire && wrCtrl && wStrb[0] && wData[flm_pkg::CTRL_SW_RESET_BIT];

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rstCount <= flm_pkg::RST_CNT_W'(flm_pkg::RESET_PULSE_CYCLES);
         resetPinOut <= 1'b0;
         resetPinOe <= 1'b1;
      end else begin
         if (swReset) begin
            rstCount <= flm_pkg::RST_CNT_W'(flm_pkg::RESET_PULSE_CYCLES);
         end else if (rstCount != '0) begin
            rstCount <= rstCount - 1'b1;
         end
         resetPinOut <= 1'b0;
         resetPinOe <= swReset || (rstCount > flm_pkg::RST_CNT_W'(1));
      end
   end

   // ===========================================
   // Modulator
   // Tone follows data level
   flm_tone_nco #(
      .PHASE_W(flm_pkg::PHASE_W),
      .MARK_INC(flm_pkg::MARK_INC),
      .SPACE_INC(flm_pkg::SPACE_INC)
   ) u_nco (
      .core_clk(core_clk),
      .rstn(rstn),
      .enable(txRun),
      .selMark(txDataSync),
      .dacWord(toneOutput)
   );

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         oscAmpEnable <= 1'b1;
         toneOutputEnable <= 1'b0;
      end else begin
         oscAmpEnable <= !clockSelectSync;
         toneOutputEnable <= txRun;
      end
   end

   // ===========================================
   // Demodulator: half-period timing of midscale crossings
   logic lastAbove;
   logic sampleAbove;
   logic crossing;
   logic [CNT_W-1:0] halfCount;
   logic [CNT_W-1:0] winCount;
   logic winEnd;
   logic rxBit;
   logic [ADC_W-1:0] peakMax;
   logic [ADC_W-1:0] peakMin;
   logic [ADC_W-1:0] peakSpan;
   logic carrierDetect;

   assign sampleAbove = toneInput >= flm_pkg::ADC_MID;
   assign crossing = toneInputValid && (sampleAbove != lastAbove);
   // Window is one bit of clocks
   assign winEnd = winCount == BIT_LAST;
   assign peakSpan = peakMax - peakMin;

   always_ff @(posedge core_clk) begin
      if (!rstn || !rxRun) begin
         lastAbove <= 1'b0;
         halfCount <= '0;
         rxBit <= 1'b1;
      end else begin
         if (toneInputValid) begin
            lastAbove <= sampleAbove;
         end
         // One decision per midscale crossing, so one per tone half period
         if (crossing) begin
            halfCount <= '0;
            rxBit <= halfCount >= DECIDE;
         end else if (halfCount != HALF_SAT) begin
            halfCount <= halfCount + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn || !rxRun || winEnd) begin
         winCount <= '0;
         peakMax <= flm_pkg::ADC_MID;
         peakMin <= flm_pkg::ADC_MID;
      end else begin
         winCount <= winCount + 1'b1;
         if (toneInputValid && toneInput > peakMax) begin
            peakMax <= toneInput;
         end
         if (toneInputValid && toneInput < peakMin) begin
            peakMin <= toneInput;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn || !rxRun) begin
         carrierDetect <= 1'b0;
      end else if (winEnd) begin
         if (peakSpan > cdHigh) begin
            carrierDetect <= 1'b1;
         end else if (peakSpan < cdLow) begin
            carrierDetect <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         rxData <= 1'b1;
         carrierDetectOut <= 1'b0;
      end else begin
         rxData <= (rxRun && carrierDetect) ? rxBit : 1'b1;
         carrierDetectOut <= carrierDetect;
      end
   end

   // ===========================================
   // Interrupts
   logic cdPrev;
   logic modePrev;
   logic [flm_pkg::IRQ_W-1:0] irqEvents;
   logic [flm_pkg::IRQ_W-1:0] irqClear;

   assign irqEvents[flm_pkg::IRQ_CD_RISE_BIT] = carrierDetect && !cdPrev;
   assign irqEvents[flm_pkg::IRQ_CD_FALL_BIT] = !carrierDetect && cdPrev;
   assign irqEvents[flm_pkg::IRQ_MODE_BIT] = modulateNSync != modePrev;
   assign irqClear = (wrFire && wrIrqStatus && wStrb[0]) ? wData[flm_pkg::IRQ_W-1:0] : '0;

   // Set beats clear so no event is lost
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         cdPrev <= 1'b0;
         modePrev <= 1'b1;
         irqStatus <= '0;
         irq <= 1'b0;
      end else begin
         cdPrev <= carrierDetect;
         modePrev <= modulateNSync;
         irqStatus <= (irqStatus & ~irqClear) | irqEvents;
         irq <= |(irqStatus & irqMask);
      end
   end

   // ===========================================
   // AXI4-Lite read channel
   logic [31:0] statusWord;
   logic [31:0] readWord;
   logic readMapped;

   assign statusWord = {27'h0, oscAmpEnable, resetPinSync, rxData, !modulateNSync,
                        carrierDetect};
   assign readMapped = s_axi_araddr == flm_pkg::ADDR_CTRL
                       || s_axi_araddr == flm_pkg::ADDR_STATUS
                       || s_axi_araddr == flm_pkg::ADDR_IRQ_STATUS
                       || s_axi_araddr == flm_pkg::ADDR_IRQ_MASK
                       || s_axi_araddr == flm_pkg::ADDR_CD_HI
                       || s_axi_araddr == flm_pkg::ADDR_CD_LO;
   assign readWord = (s_axi_araddr == flm_pkg::ADDR_STATUS) ? statusWord
                   : (s_axi_araddr == flm_pkg::ADDR_IRQ_STATUS) ? {29'h0, irqStatus}
                   : (s_axi_araddr == flm_pkg::ADDR_IRQ_MASK) ? {29'h0, irqMask}
                   : (s_axi_araddr == flm_pkg::ADDR_CD_HI) ? {20'h0, cdHigh}
                   : (s_axi_araddr == flm_pkg::ADDR_CD_LO) ? {20'h0, cdLow}
                   : 32'h0;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= flm_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= readWord;
         s_axi_rresp <= readMapped ? flm_pkg::RESP_OKAY : flm_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// >>> tb/flm_modem_core_sva.sv
module flm_modem_core_sva (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic modulateN,
   input wire logic rxData,
   input wire logic carrierDetectOut,
   input wire logic externalClockSelect,
   input wire logic oscAmpEnable,
   input wire logic [flm_pkg::DAC_W-1:0] toneOutput,
   input wire logic toneOutputEnable,
   input wire logic resetPinIn,
   input wire logic resetPinOut,
   input wire logic resetPinOe,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   // ===========================================
   // Mode sequences, six cycles to cover the pin synchronisers
   sequence s_tx_live;
      (!modulateN && resetPinIn && !resetPinOe) [*6];
   endsequence
   sequence s_rx_steady;
      modulateN [*6];
   endsequence

   // ===========================================
   // Assertions
   a_tx_tone_on: assert property (s_tx_live |-> toneOutputEnable)
      else $error("modulator not running in transmit mode");
   a_rx_tone_off: assert property (s_rx_steady |-> !toneOutputEnable && toneOutput == flm_pkg::DAC_MID)
      else $error("tone output active in receive mode");
   a_tx_rx_idle: assert property ((!modulateN) [*6] |-> rxData && !carrierDetectOut)
      else $error("receive outputs not idle while transmitting");
   a_nocarrier_mark: assert property ((!carrierDetectOut) [*3] |-> rxData)
      else $error("data output not idle without carrier");
   a_osc_external: assert property (externalClockSelect [*5] |-> !oscAmpEnable)
      else $error("crystal amplifier on with external clock");
   a_osc_crystal: assert property ((!externalClockSelect) [*5] |-> oscAmpEnable)
      else $error("crystal amplifier off in crystal mode");
   a_power_pulse: assert property ($rose(rstn) |-> (resetPinOe && !resetPinOut) [*8])
      else $error("reset pin not driven low after reset");
   // Loose bound: a coarse sine table may step far, a phase jump steps further
   a_phase_cont: assert property (toneOutputEnable && $past(toneOutputEnable)
      |-> 10'(toneOutput - $past(toneOutput) + 10'h40) <= 10'h80)
      else $error("tone output jumped");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
endmodule

bind flm_modem_core flm_modem_core_sva u_sva (.core_clk(core_clk), .rstn(rstn),
   .modulateN(modulateN), .rxData(rxData), .carrierDetectOut(carrierDetectOut),
   .externalClockSelect(externalClockSelect), .oscAmpEnable(oscAmpEnable),
   .toneOutput(toneOutput), .toneOutputEnable(toneOutputEnable), .resetPinIn(resetPinIn),
   .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> tb/flm_host_uart.sv
module flm_host_uart #(
   parameter int unsigned BIT_CYCLES = 2000
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic sendReq,
   input wire logic [7:0] sendByte,
   output logic txData,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [10:0] frame;
   logic [3:0] bitsLeft;
   int unsigned slotCnt;

   // ===========================================
   // Serial character sender, idle at mark
   assign txData = frame[0];
   assign busy = (bitsLeft != 4'h0);
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         frame <= 11'h7ff;
         bitsLeft <= 4'h0;
         slotCnt <= 0;
      end else if (sendReq && !busy) begin
         frame <= {1'b1, ^sendByte, sendByte, 1'b0};
         bitsLeft <= 4'hb;
         slotCnt <= 0;
      end else if (busy && slotCnt == BIT_CYCLES - 1) begin
         frame <= {1'b1, frame[10:1]};
         bitsLeft <= bitsLeft - 4'h1;
         slotCnt <= 0;
      end else if (busy) begin
         slotCnt <= slotCnt + 1;
      end
   end
endmodule

// >>> tb/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned BITS = 2000;
   logic core_clk = 1'b0;
   logic rstn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr, sendByte;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic modulateN, txData, rxData, carrierDetectOut, externalClockSelect, oscAmpEnable;
   logic toneInputValid, toneOutputEnable, resetPinIn, resetPinOut, resetPinOe, irq;
   logic sendReq, hostBusy, toneHigh;
   logic [11:0] toneInput, amp;
   logic [9:0] toneOutput;
   logic [7:0] regAddr [5] = '{8'h10, 8'h14, 8'h0c, 8'h08, 8'h40};
   logic [31:0] regVal [5] = '{32'h18f, 32'h10a, 32'h0, 32'h0, 32'h0};
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   int halfLen = 1000;
   int phaseCnt = 0;

   // Clock at CLK_HZ, only bit timing, DECIDE_CYCLES and the line tone source are scaled down
   always #2 core_clk = ~core_clk;
   // Pin pulled up unless the block drives it low
   assign resetPinIn = resetPinOe ? 1'b0 : 1'b1;

   flm_modem_core #(.BIT_CYCLES(BITS), .DECIDE_CYCLES(772)) u_dut (.core_clk(core_clk),
      .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .modulateN(modulateN), .txData(txData), .rxData(rxData),
      .carrierDetectOut(carrierDetectOut), .externalClockSelect(externalClockSelect),
      .oscAmpEnable(oscAmpEnable), .toneInput(toneInput), .toneInputValid(toneInputValid),
      .toneOutput(toneOutput), .toneOutputEnable(toneOutputEnable), .resetPinIn(resetPinIn),
      .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .irq(irq));
   flm_host_uart #(.BIT_CYCLES(BITS)) u_host (.core_clk(core_clk), .rstn(rstn),
      .sendReq(sendReq), .sendByte(sendByte), .txData(txData), .busy(hostBusy));

   // ===========================================
   // Line tone source: square wave, span and crossings are what matter
   always @(posedge core_clk) begin
      phaseCnt <= (phaseCnt >= halfLen - 1) ? 0 : phaseCnt + 1;
      if (phaseCnt >= halfLen - 1) begin
         toneHigh <= ~toneHigh;
      end
      toneInput <= toneHigh ? flm_pkg::ADC_MID + amp : flm_pkg::ADC_MID - amp;
   end
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         num_errors++;
         wrap_up();
      end
   end

   // ===========================================
   // Tasks
   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      check_word({31'h0, got}, {31'h0, exp});
   endtask
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      bready <= 1'b0;
      check_word({30'h0, bresp}, {30'h0, flm_pkg::RESP_OKAY});
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic pulse_len(output int n);
      n = 0;
      while (resetPinOe === 1'b1 && n < 3000) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   task automatic wait_carrier(input logic val);
      int n;
      n = 0;
      while (carrierDetectOut !== val && n < 6000) begin
         @(posedge core_clk);
         n++;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ===========================================
   // Main sequence
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      logic [9:0] v;
      int n;
      {rstn, awvalid, wvalid, bready, arvalid, rready, sendReq, toneHigh} = 8'h0;
      {awaddr, araddr, sendByte, wdata, amp} = '0;
      {modulateN, toneInputValid, externalClockSelect, wstrb} = 7'h7f;
      toneInput = flm_pkg::ADC_MID;
      repeat (4) @(posedge core_clk);
      rstn <= 1'b1;
      pulse_len(n);
      check_bit(n >= 2495 && n <= 2505, 1'b1);
      for (int i = 0; i < 5; i++) begin
         axi_read(regAddr[i], d, r);
         check_word(d, regVal[i]);
         check_word({30'h0, r}, {30'h0, (i == 4) ? flm_pkg::RESP_SLVERR : flm_pkg::RESP_OKAY});
      end
      repeat (6) @(posedge core_clk);
      check_bit(oscAmpEnable, 1'b0);
      externalClockSelect <= 1'b0;
      repeat (6) @(posedge core_clk);
      check_bit(oscAmpEnable, 1'b1);
      $display("reset and registers done");
      axi_write(flm_pkg::ADDR_IRQ_MASK, 32'h7);
      amp <= 12'd300;
      wait_carrier(1'b1);
      check_bit(carrierDetectOut, 1'b1);
      halfLen <= 545;
      repeat (1200) @(posedge core_clk);
      check_bit(rxData, 1'b0);
      halfLen <= 1000;
      repeat (2100) @(posedge core_clk);
      check_bit(rxData, 1'b1);
      check_bit(irq, 1'b1);
      axi_read(flm_pkg::ADDR_IRQ_STATUS, d, r);
      check_word(d, 32'h1);
      axi_write(flm_pkg::ADDR_IRQ_STATUS, 32'h1);
      repeat (3) @(posedge core_clk);
      check_bit(irq, 1'b0);
      $display("receive tones done");
      amp <= 12'd100;
      wait_carrier(1'b0);
      check_bit(carrierDetectOut, 1'b0);
      repeat (4) @(posedge core_clk);
      check_bit(rxData, 1'b1);
      axi_read(flm_pkg::ADDR_IRQ_STATUS, d, r);
      check_word(d, 32'h2);
      axi_write(flm_pkg::ADDR_IRQ_MASK, 32'h4);
      repeat (3) @(posedge core_clk);
      check_bit(irq, 1'b0);
      axi_write(flm_pkg::ADDR_IRQ_STATUS, 32'h2);
      $display("carrier loss done");
      modulateN <= 1'b0;
      repeat (8) @(posedge core_clk);
      check_bit(toneOutputEnable, 1'b1);
      check_bit(irq, 1'b1);
      v = toneOutput;
      repeat (5000) @(posedge core_clk);
      check_bit(toneOutput !== v, 1'b1);
      sendByte <= 8'ha5;
      sendReq <= 1'b1;
      @(posedge core_clk);
      sendReq <= 1'b0;
      repeat (24000) @(posedge core_clk);
      check_bit(hostBusy, 1'b0);
      check_bit(rxData, 1'b1);
      axi_read(flm_pkg::ADDR_STATUS, d, r);
      check_word(d & 32'h2, 32'h2);
      modulateN <= 1'b1;
      repeat (8) @(posedge core_clk);
      check_bit(toneOutputEnable, 1'b0);
      check_word({22'h0, toneOutput}, {22'h0, flm_pkg::DAC_MID});
      $display("transmit done");
      axi_write(flm_pkg::ADDR_CTRL, 32'h1);
      repeat (2) @(posedge core_clk);
      check_bit(resetPinOe, 1'b1);
      pulse_len(n);
      check_bit(n >= 2490 && n <= 2505, 1'b1);
      $display("soft reset done");
      wrap_up();
   end
endmodule
